// >>> hw/okc_pkg.sv
// constants for the overlay key and clip stage
package okc_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [5:0] OKC_ADDR_CTRL = 6'h00;
  localparam logic [5:0] OKC_ADDR_KEY = 6'h04;
  localparam logic [5:0] OKC_ADDR_MASK = 6'h08;
  localparam logic [5:0] OKC_ADDR_CLIP = 6'h0c;
  localparam logic [5:0] OKC_ADDR_ALPHA0 = 6'h10;
  localparam logic [5:0] OKC_ADDR_ALPHA1 = 6'h14;
  localparam logic [5:0] OKC_ADDR_STATUS = 6'h18;
  localparam logic [5:0] OKC_ADDR_SIZE = 6'h1c;
  localparam logic [5:0] OKC_ADDR_OFFS = 6'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int OKC_CTRL_UNIT_ON = 0;
  localparam int OKC_CTRL_KEY_EN = 1;
  localparam int OKC_CTRL_CLIP_EN = 2;
  localparam int OKC_CHROMA_IGNORE_COUNT_LSB = 8;
  localparam int OKC_STAT_UNIT_TYPE = 4;
  localparam int OKC_STAT_BW_ERR = 5;
  localparam int OKC_STAT_POS_LSB = 8;
  localparam int OKC_GEO_HI_LSB = 16;

  // ---------------------------------------------------------------
  // reset and fixed values
  // ---------------------------------------------------------------
  localparam logic [7:0] OKC_LUMA_FLOOR_RST = 8'h10;
  localparam logic [7:0] OKC_LUMA_CEIL_RST = 8'heb;
  localparam logic [7:0] OKC_CHROMA_FLOOR_RST = 8'h10;
  localparam logic [7:0] OKC_CHROMA_CEIL_RST = 8'hf0;
  localparam logic [7:0] OKC_FIXED_FLOOR = 8'h10;
  localparam logic [7:0] OKC_FIXED_CEIL = 8'hf0;
  localparam logic [2:0] OKC_MASK_MAX = 3'h4;
  localparam logic [7:0] OKC_ALPHA_FULL = 8'h80;
  localparam int OKC_POS_W = 12;

endpackage

// >>> hw/okc_stage.sv
// overlay chroma key, alpha blend, output clip stage with avalon-mm registers
//
// Register access over Avalon-MM and the address map were left to the implementer.
module okc_stage
  import okc_pkg::*;
#(
  parameter int POS_W = okc_pkg::OKC_POS_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // timing and unit state
  input wire logic line_start,
  input wire logic field_start,
  input wire logic active_video,
  input wire logic transfer_mode,
  input wire logic [23:0] transfer_byte_count,
  input wire logic fetch_bandwidth_error,
  // background and overlay pixel in
  input wire logic pix_valid,
  input wire logic pix_odd,
  input wire logic [7:0] bg_y,
  input wire logic [7:0] bg_u,
  input wire logic [7:0] bg_v,
  input wire logic ov_present,
  input wire logic [7:0] ov_y,
  input wire logic [7:0] ov_u,
  input wire logic [7:0] ov_v,
  // processed pixel out
  output logic out_valid,
  output logic [7:0] out_y,
  output logic [7:0] out_u,
  output logic [7:0] out_v
);
  import okc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ctrl;
    logic [23:0] key;
    logic [2:0] mask_y;
    logic [2:0] chroma_ignore_count;
    logic [31:0] clip;
    logic [7:0] alpha0;
    logic [7:0] alpha1;
    logic [POS_W-1:0] pic_width;
    logic [POS_W-1:0] pic_height;
    logic [POS_W-1:0] pic_hoff;
    logic [POS_W-1:0] pic_voff;
    logic ack;
    logic [31:0] rdata;
    logic [POS_W-1:0] pix_cnt;
    logic [POS_W-1:0] line_cnt;
    logic [POS_W-1:0] last_x;
    logic s1_valid;
    logic s1_img;
    logic [7:0] s1_y;
    logic [7:0] s1_u;
    logic [7:0] s1_v;
    logic o_valid;
    logic [7:0] o_y;
    logic [7:0] o_u;
    logic [7:0] o_v;
  } okc_state_s;

  okc_state_s st_r;
  okc_state_s st_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // ignore counts above four saturate, so a wild value cannot mask the whole byte
  function automatic logic key_match(input logic [7:0] px, input logic [7:0] key, input logic [2:0] cnt);
    logic [2:0] c;
    logic [7:0] m;
    c = (cnt > OKC_MASK_MAX) ? OKC_MASK_MAX : cnt;
    m = 8'hff << c;
    return ((px & m) == (key & m));
  endfunction

  // 7-bit weight out of 128; 0x40 gives the mean rounded down
  function automatic logic [7:0] blend(input logic [7:0] ov, input logic [7:0] bg, input logic [7:0] a);
    logic [15:0] sum;
    sum = 16'(ov) * 16'(a[6:0]) + 16'(bg) * (16'h0080 - 16'(a[6:0]));
    if (a[7]) begin
      return ov;
    end
    return sum[14:7];
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] val, input logic [7:0] lo, input logic [7:0] hi);
    if (val <= lo) begin
      return lo;
    end
    if (val >= hi) begin
      return hi;
    end
    return val;
  endfunction

  // one spare bit so an area that ends at the top of the counter does not wrap to zero
  function automatic logic in_span(input logic [POS_W-1:0] pos, input logic [POS_W-1:0] off,
                                   input logic [POS_W-1:0] len);
    logic [POS_W:0] last;
    last = {1'b0, off} + {1'b0, len};
    return ({1'b0, pos} >= {1'b0, off}) && ({1'b0, pos} < last);
  endfunction

  // ---------------------------------------------------------------
  // combinational decode
  // ---------------------------------------------------------------
  logic unit_on;
  logic key_en;
  logic clip_en;
  logic keyed;
  logic in_img;
  logic [7:0] alpha_y;
  logic [7:0] alpha_uv;
  logic [7:0] lfloor;
  logic [7:0] lceil;
  logic [7:0] cfloor;
  logic [7:0] cceil;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic bus_req;
  logic bus_take;

  assign unit_on = st_r.ctrl[OKC_CTRL_UNIT_ON];
  assign key_en = st_r.ctrl[OKC_CTRL_KEY_EN];
  assign clip_en = st_r.ctrl[OKC_CTRL_CLIP_EN];
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & st_r.ack;
  assign avs_waitrequest = bus_req & ~st_r.ack;

  always_comb begin
    lfloor = OKC_FIXED_FLOOR;
    lceil = OKC_FIXED_CEIL;
    cfloor = OKC_FIXED_FLOOR;
    cceil = OKC_FIXED_CEIL;
    if (clip_en) begin
      lfloor = st_r.clip[7:0];
      lceil = st_r.clip[15:8];
      cfloor = st_r.clip[23:16];
      cceil = st_r.clip[31:24];
    end
  end

  always_comb begin
    // packed 4:2:2: U lsb is the even pixel's alpha bit and also governs chroma
    alpha_y = (pix_odd ? ov_v[0] : ov_u[0]) ? st_r.alpha1 : st_r.alpha0;
    alpha_uv = ov_u[0] ? st_r.alpha1 : st_r.alpha0;
    keyed = unit_on & key_en & ov_present
      & key_match(ov_y, st_r.key[7:0], st_r.mask_y)
      & key_match(ov_u, st_r.key[15:8], st_r.chroma_ignore_count)
      & key_match(ov_v, st_r.key[23:16], st_r.chroma_ignore_count);
    in_img = active_video
      & in_span(st_r.pix_cnt, st_r.pic_hoff, st_r.pic_width)
      & in_span(st_r.line_cnt, st_r.pic_voff, st_r.pic_height);
  end

  always_comb begin
    status_word = 32'h0;
    status_word[OKC_STAT_UNIT_TYPE] = 1'b1;
    status_word[OKC_STAT_BW_ERR] = fetch_bandwidth_error;
    if (transfer_mode) begin
      // low two bits track the fetch side loosely; only the word count is exact
      status_word[OKC_STAT_POS_LSB +: 24] = transfer_byte_count;
    end else begin
      status_word[OKC_STAT_POS_LSB +: POS_W] = st_r.last_x;
      status_word[OKC_STAT_POS_LSB + POS_W +: POS_W] = st_r.line_cnt;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      OKC_ADDR_CTRL: rd_mux = {29'h0, st_r.ctrl};
      OKC_ADDR_KEY: rd_mux = {8'h0, st_r.key};
      OKC_ADDR_MASK: rd_mux = {21'h0, st_r.chroma_ignore_count, 5'h0, st_r.mask_y};
      OKC_ADDR_CLIP: rd_mux = st_r.clip;
      OKC_ADDR_ALPHA0: rd_mux = {24'h0, st_r.alpha0};
      OKC_ADDR_ALPHA1: rd_mux = {24'h0, st_r.alpha1};
      OKC_ADDR_STATUS: rd_mux = status_word;
      OKC_ADDR_SIZE: rd_mux = 32'({st_r.pic_height, 4'h0, st_r.pic_width});
      OKC_ADDR_OFFS: rd_mux = 32'({st_r.pic_voff, 4'h0, st_r.pic_hoff});
      default: rd_mux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] w;
    w = 32'h0;
    st_nxt = st_r;
    // one wait cycle: data are fetched while waitrequest is high
    st_nxt.ack = bus_req & ~st_r.ack;
    if (bus_req & ~st_r.ack) begin
      st_nxt.rdata = avs_read ? rd_mux : 32'h0;
    end
    if (bus_take & avs_write) begin
      unique case (avs_address)
        OKC_ADDR_CTRL: begin
          w = merge({29'h0, st_r.ctrl}, avs_writedata, avs_byteenable);
          st_nxt.ctrl = w[2:0];
        end
        OKC_ADDR_KEY: begin
          w = merge({8'h0, st_r.key}, avs_writedata, avs_byteenable);
          st_nxt.key = w[23:0];
        end
        OKC_ADDR_MASK: begin
          w = merge({21'h0, st_r.chroma_ignore_count, 5'h0, st_r.mask_y}, avs_writedata, avs_byteenable);
          st_nxt.mask_y = w[2:0];
          st_nxt.chroma_ignore_count = w[OKC_CHROMA_IGNORE_COUNT_LSB +: 3];
        end
        OKC_ADDR_CLIP: st_nxt.clip = merge(st_r.clip, avs_writedata, avs_byteenable);
        OKC_ADDR_ALPHA0: begin
          w = merge({24'h0, st_r.alpha0}, avs_writedata, avs_byteenable);
          st_nxt.alpha0 = w[7:0];
        end
        OKC_ADDR_ALPHA1: begin
          w = merge({24'h0, st_r.alpha1}, avs_writedata, avs_byteenable);
          st_nxt.alpha1 = w[7:0];
        end
        OKC_ADDR_SIZE: begin
          w = merge(32'({st_r.pic_height, 4'h0, st_r.pic_width}), avs_writedata, avs_byteenable);
          st_nxt.pic_width = w[POS_W-1:0];
          st_nxt.pic_height = w[OKC_GEO_HI_LSB +: POS_W];
        end
        OKC_ADDR_OFFS: begin
          w = merge(32'({st_r.pic_voff, 4'h0, st_r.pic_hoff}), avs_writedata, avs_byteenable);
          st_nxt.pic_hoff = w[POS_W-1:0];
          st_nxt.pic_voff = w[OKC_GEO_HI_LSB +: POS_W];
        end
        default: w = 32'h0; // status and unmapped writes are dropped
      endcase
    end

    // position counters
    if (field_start) begin
      st_nxt.line_cnt = '0;
      st_nxt.pix_cnt = '0;
    end else if (line_start) begin
      st_nxt.line_cnt = st_r.line_cnt + 1'b1;
      st_nxt.pix_cnt = '0;
    end else if (pix_valid & active_video) begin
      st_nxt.pix_cnt = st_r.pix_cnt + 1'b1;
      st_nxt.last_x = st_r.pix_cnt;
    end

    // stage 1: key and blend
    st_nxt.s1_valid = pix_valid;
    st_nxt.s1_img = in_img;
    if (!ov_present || keyed) begin
      st_nxt.s1_y = bg_y;
      st_nxt.s1_u = bg_u;
      st_nxt.s1_v = bg_v;
    end else begin
      st_nxt.s1_y = blend(ov_y, bg_y, alpha_y);
      st_nxt.s1_u = blend(ov_u, bg_u, alpha_uv);
      st_nxt.s1_v = blend(ov_v, bg_v, alpha_uv);
    end

    // stage 2: clip is last so nothing upstream can push picture-area values out of range; pixels outside the area pass unclamped
    st_nxt.o_valid = st_r.s1_valid;
    if (st_r.s1_img) begin
      st_nxt.o_y = clamp(st_r.s1_y, lfloor, lceil);
      st_nxt.o_u = clamp(st_r.s1_u, cfloor, cceil);
      st_nxt.o_v = clamp(st_r.s1_v, cfloor, cceil);
    end else begin
      st_nxt.o_y = st_r.s1_y;
      st_nxt.o_u = st_r.s1_u;
      st_nxt.o_v = st_r.s1_v;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.clip <= {OKC_CHROMA_CEIL_RST, OKC_CHROMA_FLOOR_RST, OKC_LUMA_CEIL_RST, OKC_LUMA_FLOOR_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata = st_r.rdata;
  assign out_valid = st_r.o_valid;
  assign out_y = st_r.o_y;
  assign out_u = st_r.o_u;
  assign out_v = st_r.o_v;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_key_gating: assert property (@(posedge clock) disable iff (rst)
    (pix_valid && ov_present && !(unit_on && key_en) && alpha_y[7]) |=> (st_r.s1_y == $past(ov_y)))
    else $error("overlay dropped while keying disabled");

  chk_keyed_background: assert property (@(posedge clock) disable iff (rst)
    (pix_valid && keyed) |=> (st_r.s1_y == $past(bg_y) && st_r.s1_u == $past(bg_u) && st_r.s1_v == $past(bg_v)))
    else $error("keyed pixel did not show background");

  chk_alpha_image_only: assert property (@(posedge clock) disable iff (rst)
    (pix_valid && ov_present && !keyed && alpha_y == 8'h00) |=> (st_r.s1_y == $past(bg_y)))
    else $error("alpha zero did not give image plane");

  chk_alpha_overlay_only: assert property (@(posedge clock) disable iff (rst)
    (pix_valid && ov_present && !keyed && alpha_y[7]) |=> (st_r.s1_y == $past(ov_y)))
    else $error("alpha msb did not give overlay alone");

  chk_fixed_clip: assert property (@(posedge clock) disable iff (rst)
    (st_r.s1_valid && st_r.s1_img && !clip_en) |=> (out_y >= 8'h10 && out_y <= 8'hf0 && out_u <= 8'hf0))
    else $error("fixed clamp not applied");

  chk_blank_pass: assert property (@(posedge clock) disable iff (rst)
    (st_r.s1_valid && !st_r.s1_img) ##1 out_valid |-> (out_y == $past(st_r.s1_y)))
    else $error("blanking value altered");

  chk_clip_reset: assert property (@(posedge clock)
    ($past(rst) && !rst) |-> (st_r.clip == 32'hf010eb10))
    else $error("clip limits wrong after reset");

  chk_unit_bit: assert property (@(posedge clock) disable iff (rst)
    (avs_read && avs_address == OKC_ADDR_STATUS && avs_waitrequest) |=> (avs_readdata[4] && !avs_waitrequest))
    else $error("unit type bit not one or answer late");

  chk_pixel_index: assert property (@(posedge clock) disable iff (rst)
    (pix_valid && active_video && !line_start && !field_start) |=> (st_r.last_x == $past(st_r.pix_cnt)))
    else $error("pixel index not tracking last pixel");

  chk_status_readonly: assert property (@(posedge clock) disable iff (rst)
    (bus_take && avs_write && avs_address == OKC_ADDR_STATUS)
      |=> (st_r.ctrl == $past(st_r.ctrl) && st_r.key == $past(st_r.key) && st_r.clip == $past(st_r.clip)))
    else $error("status write changed stored state");

  chk_luma_clamp: assert property (@(posedge clock) disable iff (rst)
    (st_r.s1_valid && st_r.s1_img && lfloor <= lceil) |=> (out_y >= $past(lfloor) && out_y <= $past(lceil)))
    else $error("luma outside its limits");

  chk_chroma_clamp: assert property (@(posedge clock) disable iff (rst)
    (st_r.s1_valid && st_r.s1_img && cfloor <= cceil)
      |=> (out_u >= $past(cfloor) && out_u <= $past(cceil) && out_v >= $past(cfloor) && out_v <= $past(cceil)))
    else $error("chroma outside its limits");

  chk_open_limits: assert property (@(posedge clock) disable iff (rst)
    (st_r.s1_valid && st_r.s1_img && clip_en && st_r.clip == 32'hff00ff00)
      |=> (out_y == $past(st_r.s1_y) && out_u == $past(st_r.s1_u) && out_v == $past(st_r.s1_v)))
    else $error("open limits altered a component");

  chk_alpha_half: assert property (@(posedge clock) disable iff (rst)
    (pix_valid && ov_present && !keyed && alpha_y == 8'h40)
      |=> ({1'b0, st_r.s1_y} == (({1'b0, $past(ov_y)} + {1'b0, $past(bg_y)}) >> 1)))
    else $error("alpha half did not give the mean");

endmodule

// >>> tb/okc_fmt_model.sv
// output formatter model that takes every processed pixel from the stage
module okc_fmt_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // processed pixel in
  input wire logic out_valid,
  input wire logic [7:0] out_y,
  input wire logic [7:0] out_u,
  input wire logic [7:0] out_v,
  // capture
  output logic [15:0] pix_count,
  output logic [23:0] last_pix
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // pixel sink
  // ---------------------------------------------------------------
  // no backpressure path exists, so the sink must take each pixel in the cycle out_valid is high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pix_count <= 16'h0000;
      last_pix <= 24'h000000;
    end else if (out_valid) begin
      pix_count <= pix_count + 16'h0001;
      last_pix <= {out_y, out_u, out_v};
    end
  end
endmodule

// >>> tb/okc_stage_tb.sv
// self-checking bench for the overlay key and clip stage
module okc_stage_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import okc_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock, rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, s;
  logic line_start, field_start, active_video, transfer_mode, fetch_bandwidth_error;
  logic [23:0] transfer_byte_count, last_pix;
  logic pix_valid, pix_odd, ov_present, out_valid;
  logic [7:0] bg_y, bg_u, bg_v, ov_y, ov_u, ov_v, out_y, out_u, out_v;
  logic [15:0] pix_count, npix;
  int mismatches, compares;

  okc_stage i_dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_start(line_start),
    .field_start(field_start), .active_video(active_video), .transfer_mode(transfer_mode),
    .transfer_byte_count(transfer_byte_count), .fetch_bandwidth_error(fetch_bandwidth_error),
    .pix_valid(pix_valid), .pix_odd(pix_odd), .bg_y(bg_y), .bg_u(bg_u), .bg_v(bg_v),
    .ov_present(ov_present), .ov_y(ov_y), .ov_u(ov_u), .ov_v(ov_v), .out_valid(out_valid),
    .out_y(out_y), .out_u(out_u), .out_v(out_v));

  okc_fmt_model i_fmt (.clock(clock), .rst(rst), .out_valid(out_valid), .out_y(out_y),
    .out_u(out_u), .out_v(out_v), .pix_count(pix_count), .last_pix(last_pix));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // slave updates only by nonblocking assignment, so these reads see the edge's own values
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      mismatches++;
      conclude();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask

  task automatic pulse(input logic fld);
    @(posedge clock);
    field_start <= fld;
    line_start <= !fld;
    @(posedge clock);
    field_start <= 1'b0;
    line_start <= 1'b0;
  endtask

  // one pixel in, then its result checked when out_valid shows
  task automatic px(input logic odd, input logic pres, input logic [23:0] bg, input logic [23:0] ov,
                    input logic [23:0] ex);
    int n;
    @(posedge clock);
    pix_valid <= 1'b1;
    pix_odd <= odd;
    ov_present <= pres;
    {bg_y, bg_u, bg_v} <= bg;
    {ov_y, ov_u, ov_v} <= ov;
    @(posedge clock);
    pix_valid <= 1'b0;
    npix++;
    for (n = 0; n < 4; n++) begin
      @(negedge clock);
      if (out_valid === 1'b1) break;
    end
    if (n == 4) begin
      mismatches++;
      conclude();
    end
    cmp({8'h00, out_y, out_u, out_v}, {8'h00, ex}, "pixel out");
  endtask

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {avs_read, avs_write, line_start, field_start, active_video, pix_valid, pix_odd} = 7'h00;
    {transfer_mode, fetch_bandwidth_error, ov_present} = 3'h0;
    {avs_address, avs_writedata, transfer_byte_count} = 62'h0;
    avs_byteenable = 4'hf;
    {bg_y, bg_u, bg_v, ov_y, ov_u, ov_v} = 48'h0;
    {mismatches, compares, npix} = 0;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(OKC_ADDR_CLIP, s);
    cmp(s, 32'hf010eb10, "clip reset");
    avs_byteenable <= 4'h2;
    wr(OKC_ADDR_CLIP, 32'h5555c855);
    avs_byteenable <= 4'hf;
    rd(OKC_ADDR_CLIP, s);
    cmp(s, 32'hf010c810, "clip lane write");
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd(OKC_ADDR_CLIP, s);
    cmp(s, 32'hf010eb10, "clip after mid reset");
    wr(6'h24, 32'hffffffff);
    rd(6'h24, s);
    cmp(s, 32'h00000000, "unmapped read");
    fetch_bandwidth_error <= 1'b1;
    rd(OKC_ADDR_STATUS, s);
    cmp(s & 32'h30, 32'h30, "status type bw");
    fetch_bandwidth_error <= 1'b0;
    rd(OKC_ADDR_STATUS, s);
    cmp(s & 32'h30, 32'h10, "status type");
    transfer_mode <= 1'b1;
    transfer_byte_count <= 24'h123456;
    rd(OKC_ADDR_STATUS, s);
    cmp(s & 32'hfffffc00, 32'h12345400, "byte count");
    transfer_mode <= 1'b0;
    active_video <= 1'b1;
    // empty picture area at reset, so nothing is clamped yet
    pulse(1'b1);
    repeat (3) px(1'b0, 1'b0, 24'h050505, 24'h0, 24'h050505);
    pulse(1'b0);
    repeat (2) px(1'b0, 1'b0, 24'h050505, 24'h0, 24'h050505);
    wr(OKC_ADDR_STATUS, 32'hffffffff);
    rd(OKC_ADDR_STATUS, s);
    cmp(s & 32'hffffff30, 32'h00100110, "line pixel index");
    wr(OKC_ADDR_SIZE, 32'h08000800);
    wr(OKC_ADDR_KEY, 32'h00706150);
    wr(OKC_ADDR_ALPHA0, 32'h00);
    wr(OKC_ADDR_ALPHA1, 32'h80);
    wr(OKC_ADDR_CTRL, 32'h7);
    px(1'b0, 1'b0, 24'h05f880, 24'h0, 24'h10f080);
    px(1'b0, 1'b1, 24'h202020, 24'h506170, 24'h202020);
    px(1'b0, 1'b1, 24'h202020, 24'h516170, 24'h516170);
    px(1'b0, 1'b1, 24'h202020, 24'h506171, 24'h506171);
    px(1'b0, 1'b1, 24'h202020, 24'h506070, 24'h202020);
    wr(OKC_ADDR_MASK, 32'h1);
    px(1'b0, 1'b1, 24'h202020, 24'h516170, 24'h202020);
    wr(OKC_ADDR_MASK, 32'h4);
    px(1'b0, 1'b1, 24'h202020, 24'h5f6170, 24'h202020);
    px(1'b0, 1'b1, 24'h202020, 24'h406170, 24'h406170);
    wr(OKC_ADDR_MASK, 32'h100);
    px(1'b0, 1'b1, 24'h202020, 24'h506171, 24'h202020);
    wr(OKC_ADDR_MASK, 32'h400);
    px(1'b0, 1'b1, 24'h202020, 24'h50617f, 24'h202020);
    px(1'b0, 1'b1, 24'h202020, 24'h50618f, 24'h50618f);
    wr(OKC_ADDR_MASK, 32'h0);
    wr(OKC_ADDR_CTRL, 32'h5);
    px(1'b0, 1'b1, 24'h202020, 24'h506170, 24'h506170);
    wr(OKC_ADDR_CTRL, 32'h6);
    px(1'b0, 1'b1, 24'h202020, 24'h506170, 24'h506170);
    wr(OKC_ADDR_CTRL, 32'h7);
    wr(OKC_ADDR_ALPHA0, 32'h40);
    px(1'b0, 1'b1, 24'h202020, 24'h606060, 24'h404040);
    px(1'b0, 1'b1, 24'h008080, 24'h308080, 24'h188080);
    px(1'b1, 1'b1, 24'h202020, 24'h906061, 24'h904040);
    wr(OKC_ADDR_CLIP, 32'hc030a020);
    px(1'b0, 1'b0, 24'hb025d0, 24'h0, 24'ha030c0);
    wr(OKC_ADDR_CLIP, 32'hff00ff00);
    px(1'b0, 1'b0, 24'h02fe01, 24'h0, 24'h02fe01);
    wr(OKC_ADDR_CTRL, 32'h3);
    px(1'b0, 1'b0, 24'h02fe01, 24'h0, 24'h10f010);
    wr(OKC_ADDR_OFFS, 32'h00000700);
    px(1'b0, 1'b0, 24'h02fe01, 24'h0, 24'h02fe01);
    wr(OKC_ADDR_OFFS, 32'h0);
    active_video <= 1'b0;
    px(1'b0, 1'b0, 24'h02fe01, 24'h0, 24'h02fe01);
    @(negedge clock);
    cmp({16'h0, pix_count}, {16'h0, npix}, "pixels delivered");
    cmp({8'h00, last_pix}, 32'h0002fe01, "formatter last pixel");
    conclude();
  end
endmodule
